// *** core/vvt_defines.svh ***
// Constants for the variable vector table lookup
// Contract
// - The 256 bytes from the vector base register form the relocatable table.
// - Each entry is four consecutive bytes, routine address, low to high.
// - Every entry offset is added to the vector base register.
// - Number 0, breakpoint instruction, offsets +0..+3, never masked.
// - DMA channels 0..3 map to numbers 8..11, channel 0 at +32.
// - Timer A channels 0..4 map to numbers 12..16 from +48.
// - Serial 0 transmit/receive are 17/18; serial 1 are 19/20.
// - Timer B channels 0..4 map to numbers 21..25 from +84.
// - External pins descend: highest pin 5 is 26, lowest pin 0 is 31.
// - Timer B channel 5 maps to number 32, offsets +128..+131.
// - Serial 2..4 each take transmit/NACK then receive/ACK, numbers 33..38.
// - Serial 2..4 collision/start-stop map to 39..41; 3 and 4 add fault.
// - Conversion done maps to 42, key input to 43.
// - Numbers 44..63 are software only, offsets +176..+255, never masked.
// - In I2C mode transmit/receive serve NACK/ACK, collision serves start/stop.
// - Serial 3/4 collision vector serves fault error when slave select chosen outside I2C mode.
// - Maskable peripheral requests blocked while the enable flag is zero.
`ifndef VVT_DEFINES_SVH
`define VVT_DEFINES_SVH

`define VVT_NUM_W         6
`define VVT_CH_W          3
`define VVT_SERIAL_CH_N   5
`define VVT_WORD_W        32
`define VVT_BYTE_W        8
`define VVT_CNT_W         2
`define VVT_ENTRY_SHIFT   2
`define VVT_TABLE_BYTES   9'h100
`define VVT_LAST_BYTE     2'h3
`define VVT_BASE_RST_BIT  1'b0

`define VVT_NUM_BRK       6'h00
`define VVT_NUM_DMA0      6'h08
`define VVT_NUM_TA0       6'h0C
`define VVT_NUM_UART0_TX  6'h11
`define VVT_NUM_UART1_TX  6'h13
`define VVT_NUM_TB0       6'h15
`define VVT_NUM_PIN0      6'h1F
`define VVT_NUM_TB5       6'h20
`define VVT_NUM_UART2_TX  6'h21
`define VVT_NUM_COLL2     6'h27
`define VVT_NUM_ADC       6'h2A
`define VVT_NUM_KEY       6'h2B
`define VVT_NUM_SOFT0     6'h2C

`define VVT_CH_DMA_N      3'h4
`define VVT_CH_TA_N       3'h5
`define VVT_CH_TB5        3'h5
`define VVT_CH_PIN_N      3'h6
`define VVT_CH_UART1      3'h1
`define VVT_CH_UART2      3'h2
`define VVT_CH_FAULT0     3'h3
`define VVT_CH_SERIAL_N   3'h5

`endif

// *** core/vvt_pkg.sv ***
// Types shared by the variable vector table lookup
`include "vvt_defines.svh"
package vvt_pkg;

    typedef enum logic [3:0] {
        SRC_BRK        = 4'h0,
        SRC_DMA        = 4'h1,
        SRC_TIMER_A    = 4'h2,
        SRC_UART_TX    = 4'h3,
        SRC_UART_RX    = 4'h4,
        SRC_TIMER_B    = 4'h5,
        SRC_EXT_PIN    = 4'h6,
        SRC_BUS_COLL   = 4'h7,
        SRC_START_STOP = 4'h8,
        SRC_FAULT      = 4'h9,
        SRC_NACK       = 4'hA,
        SRC_ACK        = 4'hB,
        SRC_ADC        = 4'hC,
        SRC_KEY        = 4'hD,
        SRC_SOFT       = 4'hE
    } src_kind_t;

    typedef struct packed {
        src_kind_t                kind;
        logic [`VVT_CH_W-1:0]     channel;
        logic [`VVT_NUM_W-1:0]    soft_num;
    } irq_req_t;

    typedef struct packed {
        logic [`VVT_SERIAL_CH_N-1:0] i2c_mode;
        logic [`VVT_SERIAL_CH_N-1:0] ss_select;
    } serial_mode_t;

    typedef struct packed {
        logic                     valid;
        logic                     maskable;
        logic [`VVT_NUM_W-1:0]    number;
    } vec_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE  = 2'b10
    } fetch_state_t;

endpackage

// *** core/vector_source_map.sv ***
// Maps an interrupt source and serial mode to its vector number
`timescale 1ns/1ps
`include "vvt_defines.svh"
module vector_source_map
    import vvt_pkg::*;
(
    input  wire irq_req_t     req,
    input  wire serial_mode_t mode,
    output vec_sel_t          sel
);

    logic [`VVT_CH_W-1:0]  ch;
    logic [`VVT_CH_W-1:0]  ch_m2;
    logic                  hi_serial;
    logic                  i2c;
    logic                  ss;

    assign ch        = req.channel;
    assign ch_m2     = ch - `VVT_CH_UART2;
    assign hi_serial = (ch >= `VVT_CH_UART2) && (ch < `VVT_CH_SERIAL_N);
    assign i2c       = hi_serial && mode.i2c_mode[ch];
    assign ss        = hi_serial && (ch >= `VVT_CH_FAULT0) && mode.ss_select[ch];

    always_comb
    begin
        sel          = '0;
        sel.maskable = 1'b1;
        unique case (req.kind)
            SRC_BRK:
            begin
                sel.valid    = 1'b1;
                sel.maskable = 1'b0;
                sel.number   = `VVT_NUM_BRK;
            end
            SRC_DMA:
            begin
                sel.valid  = ch < `VVT_CH_DMA_N;
                sel.number = `VVT_NUM_DMA0 + {3'h0, ch};
            end
            SRC_TIMER_A:
            begin
                sel.valid  = ch < `VVT_CH_TA_N;
                sel.number = `VVT_NUM_TA0 + {3'h0, ch};
            end
            SRC_UART_TX, SRC_NACK, SRC_UART_RX, SRC_ACK:
            begin
                if (ch < `VVT_CH_UART2)
                begin
                    sel.valid  = (req.kind == SRC_UART_TX) || (req.kind == SRC_UART_RX);
                    sel.number = (ch == `VVT_CH_UART1) ? `VVT_NUM_UART1_TX
                                                       : `VVT_NUM_UART0_TX;
                end
                else
                begin
                    sel.valid  = hi_serial &&
                                 (((req.kind == SRC_NACK) || (req.kind == SRC_ACK)) == i2c);
                    sel.number = `VVT_NUM_UART2_TX + {2'h0, ch_m2, 1'b0};
                end
                if ((req.kind == SRC_UART_RX) || (req.kind == SRC_ACK))
                    sel.number = sel.number + 6'h01;
            end
            SRC_TIMER_B:
            begin
                sel.valid  = ch <= `VVT_CH_TB5;
                sel.number = (ch == `VVT_CH_TB5) ? `VVT_NUM_TB5
                                                 : `VVT_NUM_TB0 + {3'h0, ch};
            end
            SRC_EXT_PIN:
            begin
                sel.valid  = ch < `VVT_CH_PIN_N;
                sel.number = `VVT_NUM_PIN0 - {3'h0, ch};
            end
            SRC_BUS_COLL, SRC_START_STOP, SRC_FAULT:
            begin
                if (req.kind == SRC_START_STOP)
                    sel.valid = i2c;
                else if (req.kind == SRC_FAULT)
                    sel.valid = ss && !i2c;
                else
                    sel.valid = hi_serial && !i2c && !ss;
                sel.number = `VVT_NUM_COLL2 + {3'h0, ch_m2};
            end
            SRC_ADC:
            begin
                sel.valid  = 1'b1;
                sel.number = `VVT_NUM_ADC;
            end
            SRC_KEY:
            begin
                sel.valid  = 1'b1;
                sel.number = `VVT_NUM_KEY;
            end
            SRC_SOFT:
            begin
                sel.valid    = 1'b1;
                sel.maskable = 1'b0;
                sel.number   = req.soft_num;
            end
            default:
            begin
                sel.valid = 1'b0;
            end
        endcase
    end

endmodule // vector_source_map

// *** core/byte_assembler.sv ***
// Gathers entry bytes, lowest address first, into one word
`timescale 1ns/1ps
`include "vvt_defines.svh"
module byte_assembler #(
    parameter int BYTE_W = `VVT_BYTE_W,
    parameter int WORD_W = `VVT_WORD_W
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              load,
    input  wire logic [BYTE_W-1:0] byte_in,
    output logic      [WORD_W-1:0] word_q
);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            word_q <= '0;
        else if (clk_en && load)
            word_q <= {byte_in, word_q[WORD_W-1:BYTE_W]};
    end

endmodule // byte_assembler

// *** core/variable_vector_table_lookup.sv ***
// Variable vector table lookup: number select, base add, entry fetch
`timescale 1ns/1ps
`include "vvt_defines.svh"
module variable_vector_table_lookup
    import vvt_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire logic                   base_wr_en,
    input  wire logic [ADDR_W-1:0]      base_wr_data,
    input  wire logic                   i_flag,
    input  wire serial_mode_t           serial_mode,
    input  wire logic                   req_valid,
    input  wire irq_req_t               req,
    input  wire logic                   fetch_ack,
    input  wire logic [`VVT_BYTE_W-1:0] fetch_data,
    output logic [ADDR_W-1:0]           vector_base_register,
    output logic                        req_ready_q,
    output logic                        req_reject_q,
    output logic                        fetch_req_q,
    output logic [ADDR_W-1:0]           fetch_addr_q,
    output logic                        vector_valid_q,
    output logic [`VVT_WORD_W-1:0]      vector_addr_q,
    output logic [`VVT_NUM_W-1:0]       vector_number_q
);

    // ==========================================================
    // Declarations
    fetch_state_t              state_q;
    logic [`VVT_CNT_W-1:0]     byte_cnt_q;
    logic [`VVT_NUM_W-1:0]     number_q;
    logic [ADDR_W-1:0]         start_base_q;
    logic [`VVT_WORD_W-1:0]    asm_word;
    vec_sel_t                  sel;
    logic                      accept;
    logic                      take;
    logic                      byte_done;
    logic                      last_byte;
    logic [ADDR_W-1:0]         entry_offset;

    // ==========================================================
    // Source to number
    vector_source_map u_map (
        .req  (req),
        .mode (serial_mode),
        .sel  (sel)
    );

    assign accept = clk_en && req_valid && req_ready_q;
    assign take = accept && sel.valid && (!sel.maskable || i_flag);
    assign byte_done = clk_en && (state_q == ST_FETCH) && fetch_req_q && fetch_ack;
    assign last_byte = byte_cnt_q == `VVT_LAST_BYTE;
    assign entry_offset = ADDR_W'({sel.number, {`VVT_ENTRY_SHIFT{1'b0}}});

    // ==========================================================
    // Base register
    // software relocates the table
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            vector_base_register <= {ADDR_W{`VVT_BASE_RST_BIT}};
        else if (clk_en && base_wr_en)
            vector_base_register <= base_wr_data;
    end

    // ==========================================================
    // Fetch sequence
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state_q     <= ST_IDLE;
            req_ready_q <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    req_ready_q <= !take;
                    if (take)
                        state_q <= ST_FETCH;
                end
                ST_FETCH:
                begin
                    if (byte_done && last_byte)
                        state_q <= ST_DONE;
                end
                ST_DONE:
                begin
                    state_q     <= ST_IDLE;
                    req_ready_q <= 1'b1;
                end
                default:
                begin
                    state_q     <= ST_IDLE;
                    req_ready_q <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Fetch address and byte count
    // Odd base costs nothing here; only the core's bus cares
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            fetch_req_q  <= 1'b0;
            fetch_addr_q <= '0;
            byte_cnt_q   <= '0;
            number_q     <= '0;
            start_base_q <= '0;
        end
        else if (clk_en)
        begin
            if (take)
            begin
                fetch_addr_q <= vector_base_register + entry_offset;
                start_base_q <= vector_base_register;
                number_q     <= sel.number;
                byte_cnt_q   <= '0;
                fetch_req_q  <= 1'b1;
            end
            else if (byte_done)
            begin
                byte_cnt_q <= byte_cnt_q + 1'b1;
                if (last_byte)
                    fetch_req_q <= 1'b0;
                else
                    fetch_addr_q <= fetch_addr_q + 1'b1;
            end
        end
    end

    // Bytes shift in as each one is acknowledged
    byte_assembler u_asm (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .load     (byte_done),
        .byte_in  (fetch_data),
        .word_q   (asm_word)
    );

    // ==========================================================
    // Results to the core
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            vector_valid_q  <= 1'b0;
            vector_addr_q   <= '0;
            vector_number_q <= '0;
            req_reject_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            req_reject_q   <= accept && !take;
            vector_valid_q <= state_q == ST_DONE;
            if (state_q == ST_DONE)
            begin
                vector_addr_q   <= asm_word;
                vector_number_q <= number_q;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    property p_base_write;
        clk_en && base_wr_en
            |=> vector_base_register == $past(base_wr_data);
    endproperty
    a_base_write: assert property (p_base_write)
        else $error("base not loaded");

    property p_in_table;
        fetch_req_q
            |-> (fetch_addr_q - start_base_q) < ADDR_W'(`VVT_TABLE_BYTES);
    endproperty
    a_in_table: assert property (p_in_table)
        else $error("fetch outside table");

    property p_offset;
        $rose(fetch_req_q) |->
            fetch_addr_q == $past(vector_base_register) + ADDR_W'({number_q, 2'b00});
    endproperty
    a_offset: assert property (p_offset)
        else $error("wrong entry address");

    // Fourth byte drops the fetch request and enters ST_DONE
    property p_four_bytes;
        byte_done && last_byte
            |=> !fetch_req_q && state_q == ST_DONE;
    endproperty
    a_four_bytes: assert property (p_four_bytes)
        else $error("entry not four bytes");

    property p_result;
        clk_en && state_q == ST_DONE
            |=> vector_valid_q && vector_addr_q == $past(asm_word);
    endproperty
    a_result: assert property (p_result)
        else $error("result not handed over");

    property p_step;
        byte_done && !last_byte
            |=> fetch_addr_q == $past(fetch_addr_q) + 1'b1;
    endproperty
    a_step: assert property (p_step)
        else $error("bytes not ascending");

    property p_idle_quiet;
        state_q == ST_IDLE
            |-> !fetch_req_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("fetch outside a lookup");

    property p_ready_drop;
        take
            |=> !req_ready_q && fetch_req_q;
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("second request possible");

    property p_brk;
        accept && req.kind == SRC_BRK && !i_flag
            |=> fetch_req_q && number_q == '0;
    endproperty
    a_brk: assert property (p_brk)
        else $error("breakpoint was masked");

    property p_mask;
        accept && sel.maskable && !i_flag
            |=> req_reject_q && !fetch_req_q;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked request taken");

    property p_soft;
        accept && req.kind == SRC_SOFT && req.soft_num >= `VVT_NUM_SOFT0
            |=> fetch_req_q && number_q == $past(req.soft_num);
    endproperty
    a_soft: assert property (p_soft)
        else $error("software vector refused");

    property p_dma;
        take && req.kind == SRC_DMA
            |=> number_q == `VVT_NUM_DMA0 + {3'h0, $past(req.channel)};
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma number wrong");

    property p_pin;
        take && req.kind == SRC_EXT_PIN
            |=> number_q == `VVT_NUM_PIN0 - {3'h0, $past(req.channel)};
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin number wrong");

    property p_unassigned;
        take && req.kind != SRC_SOFT
            |=> number_q == `VVT_NUM_BRK || number_q >= `VVT_NUM_DMA0;
    endproperty
    a_unassigned: assert property (p_unassigned)
        else $error("unassigned number used");

    property p_i2c_tx;
        accept && req.kind == SRC_UART_TX && req.channel == `VVT_CH_UART2
            && serial_mode.i2c_mode[`VVT_CH_UART2] |=> req_reject_q;
    endproperty
    a_i2c_tx: assert property (p_i2c_tx)
        else $error("tx taken in i2c mode");

    property p_done;
        vector_valid_q
            |-> vector_number_q == $past(number_q) && req_ready_q;
    endproperty
    a_done: assert property (p_done)
        else $error("result mismatch");

    c_brk:    cover property (take && req.kind == SRC_BRK);
    c_i2c:    cover property (take && req.kind == SRC_NACK);
    c_fault:  cover property (take && req.kind == SRC_FAULT);
    c_full:   cover property (vector_valid_q);
    c_reject: cover property (req_reject_q);

endmodule // variable_vector_table_lookup

// *** tb/vector_memory_model.sv ***
// Byte memory answering the vector fetch port with an adjustable delay
`timescale 1ns/1ps
module vector_memory_model #(
    parameter int ADDR_W = 24
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              fetch_req_q,
    input  wire logic [ADDR_W-1:0] fetch_addr_q,
    input  wire logic [1:0]        lat,
    output logic                   fetch_ack,
    output logic [7:0]             fetch_data
);
    logic [1:0] wait_q;

    // ========================================================
    // Byte answers
    // one byte per address, lowest first as asked
    // Ack holds until an enabled edge, else the pulse would be lost
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            fetch_ack  <= 1'b0;
            fetch_data <= 8'hFF;
            wait_q     <= 2'h0;
        end
        else if (fetch_ack)
        begin
            if (clk_en)
            begin
                fetch_ack  <= 1'b0;
                fetch_data <= ~fetch_data;
            end
        end
        else if (fetch_req_q && wait_q >= lat)
        begin
            fetch_ack  <= 1'b1;
            fetch_data <= fetch_addr_q[7:0] ^ fetch_addr_q[15:8] ^ fetch_addr_q[23:16] ^ 8'h5A;
            wait_q     <= 2'h0;
        end
        else
        begin
            // Stale data must not look valid
            fetch_data <= ~fetch_data;
            if (fetch_req_q)
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule // vector_memory_model

// *** tb/variable_vector_table_lookup_tb.sv ***
// Self-checking bench for the variable vector table lookup
`timescale 1ns/1ps
module variable_vector_table_lookup_tb import vvt_pkg::*;;
    localparam int ADDR_W = 24;

    logic              core_clk     = 1'b0;
    logic              reset_n      = 1'b0;
    logic              clk_en       = 1'b1;
    logic              base_wr_en   = 1'b0;
    logic [ADDR_W-1:0] base_wr_data = '0;
    logic              i_flag       = 1'b0;
    serial_mode_t      serial_mode  = '0;
    logic              req_valid    = 1'b0;
    irq_req_t          req          = '0;
    logic              fetch_ack;
    logic [7:0]        fetch_data;
    logic [ADDR_W-1:0] vector_base_register;
    logic              req_ready_q;
    logic              req_reject_q;
    logic              fetch_req_q;
    logic [ADDR_W-1:0] fetch_addr_q;
    logic              vector_valid_q;
    logic [31:0]       vector_addr_q;
    logic [5:0]        vector_number_q;
    logic [31:0]       seed         = 32'h6640;
    logic [31:0]       rnd          = '0;
    logic              en_rnd       = 1'b0;
    logic [1:0]        lat          = 2'h0;
    logic [ADDR_W-1:0] base         = '0;
    logic [5:0]        exp_num      = '0;
    src_kind_t         rk;
    int                fetch_k      = 0;
    int                n_fail       = 0;
    int                num_checks   = 0;

    always #2 core_clk = ~core_clk;

    variable_vector_table_lookup #(.ADDR_W(ADDR_W)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .base_wr_en(base_wr_en),
        .base_wr_data(base_wr_data), .i_flag(i_flag), .serial_mode(serial_mode),
        .req_valid(req_valid), .req(req), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
        .vector_base_register(vector_base_register), .req_ready_q(req_ready_q),
        .req_reject_q(req_reject_q), .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q),
        .vector_valid_q(vector_valid_q), .vector_addr_q(vector_addr_q),
        .vector_number_q(vector_number_q)
    );

    vector_memory_model #(.ADDR_W(ADDR_W)) memory (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .fetch_req_q(fetch_req_q),
        .fetch_addr_q(fetch_addr_q), .lat(lat), .fetch_ack(fetch_ack), .fetch_data(fetch_data)
    );

    // ========================================================
    // Expectations
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction

    function automatic logic [31:0] exp_word(input logic [ADDR_W-1:0] a);
        return {mem_byte(a + 24'h3), mem_byte(a + 24'h2), mem_byte(a + 24'h1), mem_byte(a)};
    endfunction

    // Returns {accepted, number}
    function automatic logic [6:0] exp_map(src_kind_t k, logic [2:0] c, logic [5:0] s);
        logic       ser;
        logic       i2c;
        logic       ss;
        logic [5:0] tx;
        logic [6:0] r;
        ser = c >= 3'h2 && c <= 3'h4;
        i2c = ser && serial_mode.i2c_mode[c];
        ss  = (c == 3'h3 || c == 3'h4) && serial_mode.ss_select[c];
        tx  = 6'(c < 3'h2 ? 17 + 2 * c : 29 + 2 * c);
        r   = 7'h00;
        case (k)
            SRC_BRK:        r = 7'h40;
            SRC_DMA:        if (c < 3'h4) r = {1'b1, 6'(8 + c)};
            SRC_TIMER_A:    if (c < 3'h5) r = {1'b1, 6'(12 + c)};
            SRC_UART_TX:    if (c < 3'h2 || (ser && !i2c)) r = {1'b1, tx};
            SRC_UART_RX:    if (c < 3'h2 || (ser && !i2c)) r = {1'b1, tx + 6'h1};
            SRC_NACK:       if (i2c) r = {1'b1, tx};
            SRC_ACK:        if (i2c) r = {1'b1, tx + 6'h1};
            SRC_TIMER_B:    r = c < 3'h5 ? {1'b1, 6'(21 + c)} : (c == 3'h5 ? 7'h60 : 7'h00);
            SRC_EXT_PIN:    if (c < 3'h6) r = {1'b1, 6'(31 - c)};
            SRC_BUS_COLL:   if (ser && !i2c && !ss) r = {1'b1, 6'(37 + c)};
            SRC_START_STOP: if (i2c) r = {1'b1, 6'(37 + c)};
            SRC_FAULT:      if (ss && !i2c) r = {1'b1, 6'(37 + c)};
            SRC_ADC:        r = 7'h6A;
            SRC_KEY:        r = 7'h6B;
            SRC_SOFT:       r = {1'b1, s};
            default:        r = 7'h00;
        endcase
        if (k != SRC_BRK && k != SRC_SOFT && !i_flag)
            r[6] = 1'b0;
        return r;
    endfunction

    // ========================================================
    // Compares and drivers
    task automatic check_flag(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        seed   <= lfsr(seed);
        clk_en <= en_rnd ? (seed[2:0] != 3'h0) : 1'b1;
    end

    always @(posedge core_clk)
    begin
        if (reset_n && clk_en && fetch_req_q && fetch_ack)
        begin
            check_val("fetch address", 32'(base + {exp_num, 2'b00} + 24'(fetch_k)),
                      32'(fetch_addr_q));
            fetch_k = fetch_k + 1;
        end
    end

    task automatic write_base(input logic [ADDR_W-1:0] b);
        @(posedge core_clk);
        base_wr_en   <= 1'b1;
        base_wr_data <= b;
        do
            @(posedge core_clk);
        while (!clk_en);
        base_wr_en <= 1'b0;
        base = b;
        @(posedge core_clk);
        check_val("table base", 32'(b), 32'(vector_base_register));
    endtask

    task automatic run_req(input src_kind_t k, input logic [2:0] c, input logic [5:0] s);
        logic [6:0] e;
        int         i;
        @(posedge core_clk);
        e = exp_map(k, c, s);
        exp_num = e[5:0];
        fetch_k = 0;
        lat       <= seed[9:8];
        req       <= '{kind: k, channel: c, soft_num: s};
        req_valid <= 1'b1;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (!(clk_en && req_ready_q) && i < 100);
        req_valid <= 1'b0;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (!(req_reject_q || vector_valid_q) && i < 300);
        check_flag("refusal", !e[6], req_reject_q);
        check_flag("vector valid", e[6], vector_valid_q);
        check_val("byte reads", e[6] ? 32'h4 : 32'h0, 32'(fetch_k));
        if (e[6])
        begin
            check_val("number", 32'(e[5:0]), 32'(vector_number_q));
            check_val("routine", exp_word(base + {e[5:0], 2'b00}), vector_addr_q);
        end
    endtask

    // ========================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check_val("base after reset", 32'h0, 32'(vector_base_register));
        check_flag("ready after reset", 1'b1, req_ready_q);
        en_rnd <= 1'b1;
        // Enable flag clear: software and breakpoint still pass
        for (int n = 0; n < 64; n++)
            run_req(SRC_SOFT, 3'h0, 6'(n));
        run_req(SRC_BRK, 3'h0, 6'h00);
        // Odd base near the top, allowed and fetched in the same four byte reads as an even one
        write_base(24'hFFFE01);
        i_flag <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            serial_mode <= '{i2c_mode: m[0] ? 5'h1F : 5'h00, ss_select: m[1] ? 5'h1F : 5'h00};
            for (int k = 0; k < 15; k++)
                for (int c = 0; c < 8; c++)
                    if (c == 0 || !(k inside {0, 12, 13, 14}))
                        run_req(src_kind_t'(k), 3'(c), 6'(c * 9));
        end
        i_flag <= 1'b0;
        for (int k = 1; k < 14; k++)
            run_req(src_kind_t'(k), 3'h3, 6'h00);
        repeat (300)
        begin
            @(posedge core_clk);
            rnd = seed;
            i_flag      <= rnd[4] | rnd[5];
            serial_mode <= rnd[14:5];
            if (rnd[17:15] == 3'h0)
                write_base({1'b0, rnd[30:8]});
            rk = rnd[21:18] == 4'hF ? SRC_SOFT : src_kind_t'(rnd[21:18]);
            run_req(rk, rk inside {SRC_BRK, SRC_ADC, SRC_KEY, SRC_SOFT} ? 3'h0 : rnd[24:22],
                    rnd[30:25]);
        end
        complete_run();
    end

    // Watchdog, far beyond the expected run
    initial
    begin
        repeat (80000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end
endmodule // variable_vector_table_lookup_tb
